// ### rtl/mbd_pkg.sv
// Shared constants and types for the multichannel burst DMA engine.
package mbd_pkg;
	localparam int NCH = 8;
	localparam int FIFO_BYTES = 32;
	localparam int CNT_W = 24;
	localparam int TO_W = 10;
	localparam logic [11:0] OFF_INT_EN = 12'h000;
	localparam logic [11:0] OFF_INT_FL = 12'h004;
	localparam logic [3:0]  CH_PAGE    = 4'h1;
	localparam logic [2:0]  R_CTRL     = 3'h0;
	localparam logic [2:0]  R_STAT     = 3'h1;
	localparam logic [2:0]  R_SRC      = 3'h2;
	localparam logic [2:0]  R_DST      = 3'h3;
	localparam logic [2:0]  R_CNT      = 3'h4;
	localparam logic [2:0]  R_SRLD     = 3'h5;
	localparam logic [2:0]  R_DRLD     = 3'h6;
	localparam logic [2:0]  R_CRLD     = 3'h7;
	localparam int B_EN     = 0;
	localparam int B_RLD    = 1;
	localparam int B_PRI    = 2;
	localparam int B_REQ    = 4;
	localparam int B_TOWAIT = 10;
	localparam int B_TOPRE  = 11;
	localparam int B_SRCWD  = 13;
	localparam int B_SRCINC = 15;
	localparam int B_DSTWD  = 16;
	localparam int B_DSTINC = 18;
	localparam int B_BURST  = 19;
	localparam int B_DISIE  = 24;
	localparam int B_CTZIE  = 25;
	localparam int S_ACT    = 0;
	localparam int S_PEND   = 1;
	localparam int S_CTZ    = 2;
	localparam int S_RLD    = 3;
	localparam int S_BERR   = 4;
	localparam int S_TO     = 5;
	localparam int S_TOPER  = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [5:0]  REQ_MEM = 6'h00;
	localparam logic [5:0]  RX_LO   = 6'h01;
	localparam logic [5:0]  RX_HI   = 6'h1E;
	localparam logic [5:0]  TX_LO   = 6'h21;
	localparam logic [5:0]  TX_HI   = 6'h3E;
	localparam int PRE_SH1 = 8;
	localparam int PRE_SH2 = 16;
	localparam int PRE_SH3 = 24;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b11,
		ST_CLOSE = 2'b10
	} mbd_state_t;
endpackage

// ### rtl/mbd_dma.sv
// Eight-channel burst DMA engine: registers, arbiter, channel FIFO and bus master.
//
// Functional notes
// R1: Each burst reads into FIFO, then writes out.
// R2: Eight channels, common interrupt registers, private sets.
// R3: 32-bit pointers, 24-bit count, 32-byte FIFO.
// R4: Request at once for memory, else on peripheral.
// R5: Highest level wins, round-robin within a level.
// R6: One grant at a time, released after burst.
// R7: Active follows enable; bus error drops it at once.
// R8: Exhausted without reload or disable: drop at burst end.
// R9: Active falling clears the enable bit.
// R10: Disable lets a running burst finish.
// R11: Code zero is memory to memory.
// R12: Receive and transmit code ranges pick peripheral endpoints.
// R13: Stepping ignored on peripheral endpoints.
// R14: Memory pointers step every beat when enabled.
// R15: Remaining bytes drop by each read beat.
// R16: Chunk length caps a burst at 1-32 bytes.
// R17: Beat width 1/2/4, narrower near the end.
// R18: Software clears enable, reload and flags first.
// R19: Software loads reloads, then sets enable and reload.
// R20: Setting enable starts the channel at once.
// R21: Stop interrupt on completion or bus error.
// R22: Zero-count interrupt; zero period disables timeout.
// R23: Exhausted with reload copies reloads, stays active.
// R24: 10-bit timeout counter, prescale 2^8/2^16/2^24.
// R25: Armed on request if asked, reset by request.
// R26: Interrupt pends until every set cause cleared.
// R27: Single clock, reset leaves everything idle.
//
// Chosen here: the address map and the plain strobed port.
module mbd_dma #(
	parameter int CH_COUNT = 8
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        srst,
	// Register port.
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// System bus master.
	output logic             bus_req,
	output logic             bus_write,
	output logic      [31:0] bus_addr,
	output logic      [1:0]  bus_size,
	output logic      [31:0] bus_wdata,
	output logic             bus_periph,
	output logic      [5:0]  bus_code,
	input  wire logic [31:0] bus_rdata,
	input  wire logic        bus_done,
	input  wire logic        bus_err,
	// Peripheral request lines, indexed by request code.
	input  wire logic [63:0] per_req,
	// Channel state.
	output logic      [7:0]  chan_active,
	output logic      [7:0]  chan_irq
);
	localparam int N = mbd_pkg::NCH;

	if (CH_COUNT != mbd_pkg::NCH) begin : g_chk
		$error("CH_COUNT must match the register map");
	end

	logic [31:0] ctrl_q [N];
	logic [31:0] src_q [N];
	logic [31:0] dst_q [N];
	logic [31:0] srld_q [N];
	logic [31:0] drld_q [N];
	logic [23:0] cnt_q [N];
	logic [23:0] crld_q [N];
	logic [9:0]  toper_q [N];
	logic [9:0]  tocnt_q [N];
	logic [N-1:0] act_q, pend_q, ctz_q, rld_q, berr_q, to_q, seen_q, hit_q, ien_q;
	logic [N-1:0] req_c;
	logic [63:0] per_s1_q, per_s2_q;
	logic [23:0] pre_q;
	logic [7:0]  fifo_q [mbd_pkg::FIFO_BYTES]; // see R3
	mbd_pkg::mbd_state_t st_q;
	logic [2:0]  cur_q, last_q, best_c;
	logic [5:0]  chunk_q, fill_q, rdp_q;
	logic [2:0]  beat_q;
	logic        found_c;
	logic [1:0]  bpri_c;
	logic        rd_ok, wr_ok, eng_err, eng_close, busy;
	logic [2:0]  rbeat_c, wbeat_c;
	logic [5:0]  ravail_c;
	logic        wr_ch, pg;

	function automatic logic [2:0] beat_len(input logic [1:0] wd, input logic [5:0] avail);
		beat_len = 3'h0;
		if (wd == 2'h2 && avail >= 6'h04) begin
			beat_len = 3'h4;
		end else if (wd != 2'h0 && avail >= 6'h02) begin
			beat_len = 3'h2;
		end else if (avail != 6'h00) begin
			beat_len = 3'h1;
		end
	endfunction

	function automatic logic is_rx(input logic [5:0] c);
		is_rx = (c >= mbd_pkg::RX_LO) && (c <= mbd_pkg::RX_HI);
	endfunction

	function automatic logic is_tx(input logic [5:0] c);
		is_tx = (c >= mbd_pkg::TX_LO) && (c <= mbd_pkg::TX_HI);
	endfunction

	function automatic logic [5:0] code_of(input logic [31:0] c);
		code_of = c[mbd_pkg::B_REQ +: 6];
	endfunction

	// Peripheral lines come from other logic with no timing relation, so they are synchronised.
	always_ff @(posedge clk) begin
		if (srst) begin
			per_s1_q <= 64'h0;
			per_s2_q <= 64'h0;
		end else begin
			per_s1_q <= per_req;
			per_s2_q <= per_s1_q;
		end
	end

	assign pg = reg_addr[11:8] == mbd_pkg::CH_PAGE;
	assign wr_ch = reg_wr && pg && reg_addr[1:0] == 2'h0;
	assign busy = st_q != mbd_pkg::ST_IDLE;
	assign rd_ok = st_q == mbd_pkg::ST_READ && bus_req && bus_done && !bus_err;
	assign wr_ok = st_q == mbd_pkg::ST_WRITE && bus_req && bus_done && !bus_err;
	assign eng_err = bus_req && bus_done && bus_err;
	assign eng_close = st_q == mbd_pkg::ST_CLOSE;

	// Channel requests toward the arbiter.
	always_comb begin
		for (int i = 0; i < N; i++) begin
			logic [5:0] c;
			c = code_of(ctrl_q[i]);
			req_c[i] = act_q[i] && ctrl_q[i][mbd_pkg::B_EN] && cnt_q[i] != 24'h0 &&
				(c == mbd_pkg::REQ_MEM || ((is_rx(c) || is_tx(c)) && per_s2_q[c])); // see R4 see R11 see R12
		end
	end

	// Priority first, then the first requester after the last grant.
	always_comb begin
		found_c = 1'b0;
		best_c = 3'h0;
		bpri_c = 2'h0;
		for (int k = 1; k <= N; k++) begin
			logic [2:0] ix;
			ix = 3'(int'(last_q) + k);
			if (req_c[ix] && (!found_c || ctrl_q[ix][mbd_pkg::B_PRI +: 2] > bpri_c)) begin // see R5
				found_c = 1'b1;
				best_c = ix;
				bpri_c = ctrl_q[ix][mbd_pkg::B_PRI +: 2];
			end
		end
	end

	// Beat sizing; the read side is limited by chunk and remaining count.
	always_comb begin
		ravail_c = (cnt_q[cur_q] > 24'(chunk_q)) ? chunk_q : cnt_q[cur_q][5:0];
		rbeat_c = beat_len(ctrl_q[cur_q][mbd_pkg::B_SRCWD +: 2], ravail_c); // see R17 see R16
		wbeat_c = beat_len(ctrl_q[cur_q][mbd_pkg::B_DSTWD +: 2], fill_q - rdp_q);
	end

	// Burst engine: read phase fills the FIFO, write phase drains it.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= mbd_pkg::ST_IDLE; // see R27
			cur_q <= 3'h0;
			last_q <= 3'h7;
			chunk_q <= 6'h0;
			fill_q <= 6'h0;
			rdp_q <= 6'h0;
			beat_q <= 3'h0;
			bus_req <= 1'b0;
			bus_write <= 1'b0;
			bus_addr <= 32'h0;
			bus_size <= 2'h0;
			bus_wdata <= 32'h0;
			bus_periph <= 1'b0;
			bus_code <= 6'h0;
		end else begin
			unique case (st_q)
				mbd_pkg::ST_IDLE: begin
					if (found_c) begin // see R6
						cur_q <= best_c;
						chunk_q <= 6'(ctrl_q[best_c][mbd_pkg::B_BURST +: 5]) + 6'h1; // see R16
						fill_q <= 6'h0;
						st_q <= mbd_pkg::ST_READ;
					end
				end
				mbd_pkg::ST_READ: begin
					if (!bus_req) begin
						if (rbeat_c == 3'h0) begin
							rdp_q <= 6'h0;
							st_q <= mbd_pkg::ST_WRITE; // see R1
						end else begin
							bus_req <= 1'b1;
							bus_write <= 1'b0;
							bus_periph <= is_rx(code_of(ctrl_q[cur_q]));
							bus_code <= code_of(ctrl_q[cur_q]);
							bus_addr <= src_q[cur_q];
							bus_size <= rbeat_c[2] ? 2'h2 : {1'b0, rbeat_c[1]};
							beat_q <= rbeat_c;
						end
					end else if (bus_done) begin
						bus_req <= 1'b0;
						if (bus_err) begin
							last_q <= cur_q;
							st_q <= mbd_pkg::ST_IDLE; // see R7
						end else begin
							for (int j = 0; j < 4; j++) begin
								if (3'(j) < beat_q) begin
									fifo_q[5'(fill_q + 6'(j))] <= bus_rdata[8*j +: 8];
								end
							end
							fill_q <= fill_q + 6'(beat_q);
							chunk_q <= chunk_q - 6'(beat_q);
						end
					end
				end
				mbd_pkg::ST_WRITE: begin
					if (!bus_req) begin
						if (wbeat_c == 3'h0) begin
							st_q <= mbd_pkg::ST_CLOSE;
						end else begin
							bus_req <= 1'b1;
							bus_write <= 1'b1;
							bus_periph <= is_tx(code_of(ctrl_q[cur_q]));
							bus_code <= code_of(ctrl_q[cur_q]);
							bus_addr <= dst_q[cur_q];
							bus_size <= wbeat_c[2] ? 2'h2 : {1'b0, wbeat_c[1]};
							beat_q <= wbeat_c;
							for (int j = 0; j < 4; j++) begin
								bus_wdata[8*j +: 8] <= (3'(j) < wbeat_c) ?
									fifo_q[5'(rdp_q + 6'(j))] : 8'h00;
							end
						end
					end else if (bus_done) begin
						bus_req <= 1'b0;
						rdp_q <= rdp_q + 6'(beat_q);
						if (bus_err) begin
							last_q <= cur_q;
							st_q <= mbd_pkg::ST_IDLE;
						end
					end
				end
				mbd_pkg::ST_CLOSE: begin
					last_q <= cur_q; // see R6
					st_q <= mbd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Shared prescaler and per-channel timeout counters.
	always_ff @(posedge clk) begin
		if (srst) begin
			pre_q <= 24'h0;
			tocnt_q <= '{default: 10'h0};
			seen_q <= '0;
			hit_q <= '0;
		end else begin
			pre_q <= pre_q + 24'h1;
			for (int i = 0; i < N; i++) begin
				logic [1:0] ps;
				logic tick;
				ps = ctrl_q[i][mbd_pkg::B_TOPRE +: 2];
				tick = (ps == 2'h1 && &pre_q[mbd_pkg::PRE_SH1-1:0]) ||
					(ps == 2'h2 && &pre_q[mbd_pkg::PRE_SH2-1:0]) ||
					(ps == 2'h3 && &pre_q[mbd_pkg::PRE_SH3-1:0]); // see R24
				hit_q[i] <= 1'b0;
				if (!act_q[i] || toper_q[i] == 10'h0 || ps == 2'h0) begin // see R22 see R25
					tocnt_q[i] <= 10'h0;
					seen_q[i] <= 1'b0;
				end else if (per_s2_q[code_of(ctrl_q[i])]) begin
					tocnt_q[i] <= 10'h0; // see R25
					seen_q[i] <= 1'b1;
				end else if (tick && (seen_q[i] || !ctrl_q[i][mbd_pkg::B_TOWAIT])) begin
					if (tocnt_q[i] + 10'h1 >= toper_q[i]) begin
						tocnt_q[i] <= 10'h0;
						hit_q[i] <= 1'b1;
					end else begin
						tocnt_q[i] <= tocnt_q[i] + 10'h1;
					end
				end
			end
		end
	end

	// Channel registers: software writes first, hardware events after, so events win.
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= '{default: mbd_pkg::CTRL_RST}; // see R27
			src_q <= '{default: 32'h0};
			dst_q <= '{default: 32'h0};
			srld_q <= '{default: 32'h0};
			drld_q <= '{default: 32'h0};
			cnt_q <= '{default: 24'h0};
			crld_q <= '{default: 24'h0};
			toper_q <= '{default: 10'h0};
			act_q <= '0;
			pend_q <= '0;
			ctz_q <= '0;
			rld_q <= '0;
			berr_q <= '0;
			to_q <= '0;
			ien_q <= '0;
		end else begin
			if (reg_wr && reg_addr == mbd_pkg::OFF_INT_EN) begin
				ien_q <= reg_wdata[N-1:0]; // see R2
			end
			for (int i = 0; i < N; i++) begin
				logic sel, stop, mine, ie_d, ie_z;
				logic [3:0] fl;
				logic [23:0] cn;
				sel = wr_ch && reg_addr[7:5] == 3'(i);
				mine = busy && cur_q == 3'(i);
				stop = 1'b0;
				ie_d = ctrl_q[i][mbd_pkg::B_DISIE];
				ie_z = ctrl_q[i][mbd_pkg::B_CTZIE];
				fl = {to_q[i], berr_q[i], rld_q[i], ctz_q[i]};
				cn = cnt_q[i];
				if (sel) begin
					unique case (reg_addr[4:2])
						mbd_pkg::R_CTRL: begin
							ctrl_q[i] <= reg_wdata;
							if (reg_wdata[mbd_pkg::B_EN]) begin
								act_q[i] <= 1'b1; // see R20 see R7
							end
						end
						mbd_pkg::R_STAT: begin
							fl = fl & ~reg_wdata[mbd_pkg::S_TO:mbd_pkg::S_CTZ]; // see R26
							toper_q[i] <= reg_wdata[mbd_pkg::S_TOPER +: 10];
						end
						mbd_pkg::R_SRC: src_q[i] <= reg_wdata;
						mbd_pkg::R_DST: dst_q[i] <= reg_wdata;
						mbd_pkg::R_CNT: cn = reg_wdata[23:0];
						mbd_pkg::R_SRLD: srld_q[i] <= reg_wdata;
						mbd_pkg::R_DRLD: drld_q[i] <= reg_wdata;
						mbd_pkg::R_CRLD: crld_q[i] <= reg_wdata[23:0];
					endcase
				end
				if (mine && rd_ok) begin
					cn = cnt_q[i] - 24'(beat_q); // see R15
					if (ctrl_q[i][mbd_pkg::B_SRCINC] && !is_rx(code_of(ctrl_q[i]))) begin
						src_q[i] <= src_q[i] + 32'(beat_q); // see R13 see R14
					end
				end
				if (mine && wr_ok && ctrl_q[i][mbd_pkg::B_DSTINC] &&
					!is_tx(code_of(ctrl_q[i]))) begin
					dst_q[i] <= dst_q[i] + 32'(beat_q); // see R13 see R14
				end
				if (mine && eng_err) begin
					fl[2] = 1'b1;
					stop = 1'b1; // see R7 see R21
				end else if (mine && eng_close) begin
					if (cnt_q[i] == 24'h0) begin
						fl[0] = 1'b1; // see R22
						if (ctrl_q[i][mbd_pkg::B_RLD]) begin
							src_q[i] <= srld_q[i]; // see R23
							dst_q[i] <= drld_q[i];
							cn = crld_q[i];
							fl[1] = 1'b1;
						end else begin
							stop = 1'b1; // see R8
						end
					end else if (!ctrl_q[i][mbd_pkg::B_EN]) begin
						stop = 1'b1; // see R8 see R10
					end
				end else if (act_q[i] && !mine && !ctrl_q[i][mbd_pkg::B_EN] && !sel) begin
					stop = 1'b1; // see R7
				end
				if (hit_q[i]) begin
					fl[3] = 1'b1; // see R25
				end
				if (stop) begin
					act_q[i] <= 1'b0;
					ctrl_q[i][mbd_pkg::B_EN] <= 1'b0; // see R9
				end
				cnt_q[i] <= cn;
				{to_q[i], berr_q[i], rld_q[i], ctz_q[i]} <= fl;
				pend_q[i] <= (pend_q[i] || (stop && ie_d) || (hit_q[i] && ie_d) ||
					(mine && eng_close && cnt_q[i] == 24'h0 && ie_z)) && (|fl); // see R21 see R26
			end
		end
	end

	// Read data stands in the cycle after the read strobe; unmapped addresses read zero.
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 32'h0;
			chan_active <= 8'h0;
			chan_irq <= 8'h0;
		end else begin
			chan_active <= act_q;
			chan_irq <= pend_q & ien_q; // see R2
			reg_rdata <= 32'h0;
			if (reg_rd && reg_addr == mbd_pkg::OFF_INT_EN) begin
				reg_rdata <= 32'(ien_q);
			end else if (reg_rd && reg_addr == mbd_pkg::OFF_INT_FL) begin
				reg_rdata <= 32'(pend_q & ien_q);
			end else if (reg_rd && pg && reg_addr[1:0] == 2'h0) begin
				unique case (reg_addr[4:2])
					mbd_pkg::R_CTRL: reg_rdata <= ctrl_q[reg_addr[7:5]];
					mbd_pkg::R_STAT: reg_rdata <= {6'h0, toper_q[reg_addr[7:5]], 10'h0,
						to_q[reg_addr[7:5]], berr_q[reg_addr[7:5]], rld_q[reg_addr[7:5]],
						ctz_q[reg_addr[7:5]], pend_q[reg_addr[7:5]], act_q[reg_addr[7:5]]};
					mbd_pkg::R_SRC: reg_rdata <= src_q[reg_addr[7:5]];
					mbd_pkg::R_DST: reg_rdata <= dst_q[reg_addr[7:5]];
					mbd_pkg::R_CNT: reg_rdata <= {8'h0, cnt_q[reg_addr[7:5]]};
					mbd_pkg::R_SRLD: reg_rdata <= srld_q[reg_addr[7:5]];
					mbd_pkg::R_DRLD: reg_rdata <= drld_q[reg_addr[7:5]];
					mbd_pkg::R_CRLD: reg_rdata <= {8'h0, crld_q[reg_addr[7:5]]};
				endcase
			end
		end
	end
endmodule

// ### verification/mbd_dma_props.sv
// Port-level assertion checker for the burst DMA engine.
module mbd_dma_props #(
	parameter int CH_COUNT = 8
) (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        srst,
	// Register port.
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// System bus master.
	input wire logic        bus_req,
	input wire logic        bus_write,
	input wire logic [31:0] bus_addr,
	input wire logic [1:0]  bus_size,
	input wire logic        bus_periph,
	input wire logic [5:0]  bus_code,
	input wire logic        bus_done,
	input wire logic        bus_err,
	// Channel state.
	input wire logic [7:0]  chan_active,
	input wire logic [7:0]  chan_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	a_rst_idle:
		assert property (disable iff (1'b0) srst |=> chan_active == 8'h00 && !bus_req && chan_irq == 8'h00)
		else $error("outputs busy after reset");
	a_beat_held:
		assert property (bus_req && !bus_done |=> bus_req && $stable(bus_addr) && $stable(bus_write)
			&& $stable(bus_size))
		else $error("beat changed before completion");
	a_beat_release:
		assert property (bus_req && bus_done |=> !bus_req)
		else $error("request held after completion");
	a_beat_width:
		assert property (bus_req |-> bus_size != 2'h3)
		else $error("illegal beat size");
	a_mem_route:
		assert property (bus_req && bus_code == mbd_pkg::REQ_MEM |-> !bus_periph)
		else $error("memory code reached a peripheral");
	a_rx_route:
		assert property (bus_req && bus_code >= mbd_pkg::RX_LO && bus_code <= mbd_pkg::RX_HI
			|-> bus_periph == !bus_write)
		else $error("receive route wrong");
	a_tx_route:
		assert property (bus_req && bus_code >= mbd_pkg::TX_LO && bus_code <= mbd_pkg::TX_HI
			|-> bus_periph == bus_write)
		else $error("transmit route wrong");
	a_rdata_quiet:
		assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_err_stop:
		assert property (bus_req && bus_done && bus_err
			|-> ##[1:3] ($past(chan_active) & ~chan_active) != 8'h00)
		else $error("no channel stopped on bus error");
	c_err: cover property (bus_req && bus_done && bus_err);
	c_stop: cover property ($fell(chan_active[0]));
	c_tx: cover property (bus_req && bus_periph && bus_write);
endmodule

bind mbd_dma mbd_dma_props #(.CH_COUNT(CH_COUNT)) u_props (
	.clk(clk), .srst(srst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
	.bus_periph(bus_periph), .bus_code(bus_code), .bus_done(bus_done), .bus_err(bus_err),
	.chan_active(chan_active), .chan_irq(chan_irq)
);

// ### verification/mbd_mem_model.sv
// Behavioural memory and peripheral FIFO partner on the DMA bus master.
module mbd_mem_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        srst,
	// Beat from the engine.
	input  wire logic        bus_req,
	input  wire logic        bus_write,
	input  wire logic [31:0] bus_addr,
	input  wire logic [1:0]  bus_size,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_periph,
	// Completion.
	output logic      [31:0] bus_rdata,
	output logic             bus_done,
	output logic             bus_err
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [logic [31:0]];
	logic [31:0] err_addr = 32'hFFFF_FFFF;
	logic [1:0]  last_rsize = 2'h0;
	int          lat = 0;
	int          wait_n = 0;
	int          tx_bytes = 0;
	function automatic logic [7:0] rb(logic [31:0] a);
		return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
	endfunction
	// Idle read data toggles, so a stale word is never taken for an answer.
	always @(posedge clk) begin
		bus_done <= 1'b0;
		bus_err <= 1'b0;
		bus_rdata <= ~bus_rdata;
		if (srst) begin
			wait_n = 0;
			bus_rdata <= 32'h0;
		end else if (bus_req && !bus_done) begin
			if (wait_n < lat) begin
				wait_n++;
			end else begin
				wait_n = 0;
				bus_done <= 1'b1;
				bus_err <= !bus_periph && bus_addr === err_addr;
				for (int i = 0; i < (1 << bus_size); i++) begin
					if (bus_write && bus_periph) tx_bytes++;
					else if (bus_write) mem[bus_addr + i] = bus_wdata[8*i +: 8];
					else bus_rdata[8*i +: 8] <= bus_periph ? 8'hC0 + 8'(i) : rb(bus_addr + i);
				end
				if (!bus_write) last_rsize = bus_size;
			end
		end
	end
endmodule

// ### verification/tb_multichannel_burst_dma.sv
// Self-checking bench for the eight-channel burst DMA engine.
module tb_multichannel_burst_dma;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, srst, reg_wr, reg_rd, bus_req, bus_write, bus_periph, bus_done, bus_err;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, bus_addr, bus_wdata, bus_rdata, d;
	logic [1:0]  bus_size;
	logic [5:0]  bus_code;
	logic [63:0] per_req;
	logic [7:0]  chan_active, chan_irq;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	mbd_dma #(.CH_COUNT(8)) uut (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
		.bus_periph(bus_periph), .bus_code(bus_code), .bus_rdata(bus_rdata),
		.bus_done(bus_done), .bus_err(bus_err), .per_req(per_req),
		.chan_active(chan_active), .chan_irq(chan_irq));
	mbd_mem_model u_mem (
		.clk(clk), .srst(srst), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
		.bus_size(bus_size), .bus_wdata(bus_wdata), .bus_periph(bus_periph),
		.bus_rdata(bus_rdata), .bus_done(bus_done), .bus_err(bus_err));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [11:0] ca(int n, logic [2:0] r);
		return 12'h100 + 12'(n * 32) + {7'h0, r, 2'b00};
	endfunction
	// Control word with four-byte beats, both steps on and the stop interrupt on.
	function automatic logic [31:0] cw(logic [5:0] q, logic [1:0] p, logic [4:0] c);
		return {26'h0, q} << mbd_pkg::B_REQ | {30'h0, p} << mbd_pkg::B_PRI
			| {27'h0, c} << mbd_pkg::B_BURST | 32'h2 << mbd_pkg::B_SRCWD
			| 32'h2 << mbd_pkg::B_DSTWD | 32'h1 << mbd_pkg::B_SRCINC
			| 32'h1 << mbd_pkg::B_DSTINC | 32'h1 << mbd_pkg::B_DISIE;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	task automatic setup(input int n, input logic [31:0] s, input logic [31:0] t,
		input logic [31:0] c);
		wr(ca(n, mbd_pkg::R_CTRL), 32'h0);
		wr(ca(n, mbd_pkg::R_STAT), 32'h0000_003C);
		wr(ca(n, mbd_pkg::R_SRC), s);
		wr(ca(n, mbd_pkg::R_DST), t);
		wr(ca(n, mbd_pkg::R_CNT), c);
	endtask
	task automatic wait_off(input int n);
		repeat (4) @(negedge clk);
		while (chan_active[n] !== 1'b0) @(negedge clk);
	endtask
	task automatic mchk(input logic [31:0] a, input int n, input logic [31:0] s, input bit p);
		for (int i = 0; i < n; i++) begin
			chk({24'h0, u_mem.mem[a + i]}, {24'h0, p ? 8'hC0 + 8'(i) : 8'(s + i) ^ 8'h5A});
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// The ceiling sits far above the thousand or so cycles the tests need.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		srst = 1'b1;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		per_req = 64'h0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rc(mbd_pkg::OFF_INT_EN, 32'h0);
		rc(ca(7, mbd_pkg::R_CTRL), mbd_pkg::CTRL_RST);
		rc(12'h0FC, 32'h0);
		wr(mbd_pkg::OFF_INT_EN, 32'h0000_00FF);
		rc(mbd_pkg::OFF_INT_EN, 32'h0000_00FF);
		$display("test reset done");
		setup(0, 32'h1000, 32'h2000, 32'h6);
		wr(ca(0, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h03) | 32'h1);
		wait_off(0);
		mchk(32'h2000, 6, 32'h1000, 1'b0);
		rc(ca(0, mbd_pkg::R_SRC), 32'h1006);
		rc(ca(0, mbd_pkg::R_DST), 32'h2006);
		rc(ca(0, mbd_pkg::R_CNT), 32'h0);
		chk({30'h0, u_mem.last_rsize}, 32'h1);
		rc(ca(0, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h03));
		rc(ca(0, mbd_pkg::R_STAT), 32'h6);
		rc(mbd_pkg::OFF_INT_FL, 32'h1);
		chk({24'h0, chan_irq}, 32'h1);
		wr(ca(0, mbd_pkg::R_STAT), 32'h4);
		rc(ca(0, mbd_pkg::R_STAT), 32'h0);
		chk({24'h0, chan_irq}, 32'h0);
		$display("test memory copy done");
		u_mem.lat <= 4;
		setup(1, 32'h1100, 32'h2100, 32'h4);
		wr(ca(1, mbd_pkg::R_SRLD), 32'h1200);
		wr(ca(1, mbd_pkg::R_DRLD), 32'h2200);
		wr(ca(1, mbd_pkg::R_CRLD), 32'h4);
		wr(ca(1, mbd_pkg::R_CTRL), cw(6'h00, 2'h1, 5'h03) | 32'h3);
		do begin
			rd(ca(1, mbd_pkg::R_STAT), d);
		end while (d[mbd_pkg::S_RLD] !== 1'b1);
		wr(ca(1, mbd_pkg::R_CTRL), cw(6'h00, 2'h1, 5'h03) | 32'h1);
		wait_off(1);
		mchk(32'h2100, 4, 32'h1100, 1'b0);
		mchk(32'h2200, 4, 32'h1200, 1'b0);
		rc(ca(1, mbd_pkg::R_SRC), 32'h1204);
		$display("test reload done");
		u_mem.lat <= 0;
		u_mem.err_addr <= 32'h3000;
		setup(2, 32'h3000, 32'h2300, 32'h8);
		wr(ca(2, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h07) | 32'h1);
		wait_off(2);
		chk(32'(u_mem.mem.exists(32'h2300)), 32'h0);
		rc(ca(2, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h07));
		rc(ca(2, mbd_pkg::R_STAT), 32'h12);
		$display("test bus error done");
		setup(3, 32'h5000, 32'h2400, 32'h4);
		setup(4, 32'h1400, 32'h6000, 32'h4);
		wr(ca(3, mbd_pkg::R_CTRL), cw(6'h01, 2'h0, 5'h03) | 32'h1);
		wr(ca(4, mbd_pkg::R_CTRL), cw(6'h22, 2'h3, 5'h03) | 32'h1);
		repeat (10) @(negedge clk);
		chk({31'h0, bus_req}, 32'h0);
		@(posedge clk);
		per_req <= 64'h0000_0004_0000_0002;
		while (bus_req !== 1'b1) @(negedge clk);
		chk({26'h0, bus_code}, 32'h22);
		chk({31'h0, bus_periph}, 32'h0);
		wait_off(4);
		wait_off(3);
		per_req <= 64'h0;
		mchk(32'h2400, 4, 32'h0, 1'b1);
		chk(32'(u_mem.tx_bytes), 32'h4);
		rc(ca(3, mbd_pkg::R_SRC), 32'h5000);
		rc(ca(4, mbd_pkg::R_DST), 32'h6000);
		$display("test peripheral priority done");
		u_mem.lat <= 4;
		setup(6, 32'h1600, 32'h2600, 32'h8);
		wr(ca(6, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h03) | 32'h1);
		while (bus_req !== 1'b1) @(negedge clk);
		wr(ca(6, mbd_pkg::R_CTRL), cw(6'h00, 2'h0, 5'h03));
		wait_off(6);
		mchk(32'h2600, 4, 32'h1600, 1'b0);
		chk(32'(u_mem.mem.exists(32'h2604)), 32'h0);
		rc(ca(6, mbd_pkg::R_CNT), 32'h4);
		rc(ca(6, mbd_pkg::R_STAT), 32'h0);
		$display("test disable done");
		setup(5, 32'h0, 32'h2500, 32'h4);
		wr(ca(5, mbd_pkg::R_STAT), 32'h0002_0000);
		wr(ca(5, mbd_pkg::R_CTRL), cw(6'h02, 2'h0, 5'h03) | 32'h1 << mbd_pkg::B_TOPRE | 32'h1);
		repeat (600) @(posedge clk);
		rc(ca(5, mbd_pkg::R_STAT), 32'h0002_0023);
		$display("test timeout done");
		end_of_test();
	end
endmodule
